// File: rxcfg_regs.sv
/*
 * Receiver configuration register bank on APB: filter setup, level meter,
 * frequency correction control and status, mode and pattern setup, and the
 * pattern matcher that uses them.
 * Assumes the correction loop, overflow flag and demodulated bits are on pclk;
 * the level meter reading comes from the analog side and is synchronised.
 */
`timescale 1ns/10ps
module rxcfg_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic bit_sync_disable,
  output logic [1:0] filter_bandwidth_select,
  output logic filter_widest_force,
  output logic filter_cal_pulse,
  output logic filter_init_pulse,
  output logic level_meter_enable,
  output logic level_meter_range,
  input wire logic [1:0] level_meter_reading,
  output logic freq_error_meter_enable,
  output logic freq_correction_start,
  input wire logic freq_correction_done,
  input wire logic freq_correction_fail,
  output logic freq_correction_apply_off,
  input wire logic freq_correction_integrator_overflow,
  output logic freq_correction_integrator_reset,
  output logic quadrature_amp_enable,
  output logic rx_mode_linear,
  output logic pattern_enable,
  output logic [1:0] pattern_size,
  output logic [1:0] pattern_tolerance,
  input wire logic demod_bit,
  input wire logic demod_bit_valid,
  output logic pattern_match
);
  logic [7:0] filter_q, ctl9_q, ctl10_q;
  logic [31:0] pattern_q;
  logic [1:0] level_meta_q, level_sync_q;
  logic afc_busy_q, afc_result_q, overflow_q;
  logic ready_q, started_q;
  logic [2:0] bw_eff_q;
  logic [31:0] rdata_q;
  logic access, wr_en, hit8, hit9, hit10, hitp, mapped;
  logic wr8, wr9, wr10, wrp, afc_go, ovf_clr, bw_changed;
  logic wr8_q;
  logic [7:0] reg9_rd, reg10_rd;
  logic [31:0] rd_mux;
  rxcfg_pkg::rxcfg_policy_t cal_pol, init_pol;

  // apb slave: one wait state, read data registered with pready
  assign access = psel && penable;
  assign pready = ready_q;
  assign hit8 = paddr == rxcfg_pkg::ADDR_FILTER;
  assign hit9 = paddr == rxcfg_pkg::ADDR_LEVEL_AFC;
  assign hit10 = paddr == rxcfg_pkg::ADDR_MODE_PAT;
  assign hitp = paddr == rxcfg_pkg::ADDR_PATTERN;
  assign mapped = hit8 || hit9 || hit10 || hitp;
  assign pslverr = ready_q && !mapped;
  assign prdata = rdata_q;
  assign wr_en = access && ready_q && pwrite && mapped;
  assign wr8 = wr_en && hit8;
  assign wr9 = wr_en && hit9;
  assign wr10 = wr_en && hit10;
  assign wrp = wr_en && hitp;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= access && !ready_q;
    end
  end

  assign reg9_rd = (ctl9_q & rxcfg_pkg::LEVEL_AFC_RW_MASK)
                   | {2'b00, level_sync_q, 1'b0, afc_busy_q, afc_result_q, 1'b0};
  assign reg10_rd = {overflow_q, ctl10_q[6:0] & rxcfg_pkg::MODE_PAT_RW_MASK[6:0]};

  always_comb begin
    rd_mux = '0;
    if (hit8) begin
      rd_mux = {24'h000000, filter_q};
    end else if (hit9) begin
      rd_mux = {24'h000000, reg9_rd};
    end else if (hit10) begin
      rd_mux = {24'h000000, reg10_rd};
    end else if (hitp) begin
      rd_mux = pattern_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
    end else if (access && !ready_q && !pwrite) begin
      rdata_q <= rd_mux;
    end
  end

  // software-written fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_q <= rxcfg_pkg::FILTER_RST;
      ctl9_q <= rxcfg_pkg::LEVEL_AFC_RST;
      ctl10_q <= rxcfg_pkg::MODE_PAT_RST;
      pattern_q <= rxcfg_pkg::PATTERN_RST;
    end else begin
      if (wr8) begin
        filter_q <= pwdata[7:0];
      end
      if (wr9) begin
        ctl9_q <= pwdata[7:0] & rxcfg_pkg::LEVEL_AFC_RW_MASK;
      end
      if (wr10) begin
        ctl10_q <= {1'b0, pwdata[6:0]};
      end
      if (wrp) begin
        pattern_q <= pwdata;
      end
    end
  end

  assign bit_sync_disable = filter_q[rxcfg_pkg::F_BITSYNC_OFF];
  assign filter_bandwidth_select = filter_q[rxcfg_pkg::F_BW_LSB +: 2];
  assign filter_widest_force = filter_q[rxcfg_pkg::F_WIDEST];
  assign cal_pol = rxcfg_pkg::rxcfg_policy_t'(filter_q[rxcfg_pkg::F_CAL_LSB +: 2]);
  assign init_pol = rxcfg_pkg::rxcfg_policy_t'(filter_q[rxcfg_pkg::F_INIT_LSB +: 2]);
  assign level_meter_enable = ctl9_q[rxcfg_pkg::L_ENABLE];
  assign level_meter_range = ctl9_q[rxcfg_pkg::L_RANGE];
  assign freq_error_meter_enable = ctl9_q[rxcfg_pkg::L_FREQ_ERR];
  assign freq_correction_apply_off = ctl9_q[rxcfg_pkg::L_AFC_APPLY_OFF];
  assign quadrature_amp_enable = ctl10_q[rxcfg_pkg::M_QUAD_AMP];
  assign rx_mode_linear = ctl10_q[rxcfg_pkg::M_LINEAR];
  assign pattern_enable = ctl10_q[rxcfg_pkg::M_PATTERN_ON];
  assign pattern_size = ctl10_q[rxcfg_pkg::M_PLEN_LSB +: 2];
  assign pattern_tolerance = ctl10_q[rxcfg_pkg::M_TOL_LSB +: 2];

  // filter calibration and initialisation triggers
  assign bw_changed = started_q && (bw_eff_q != {filter_widest_force, filter_bandwidth_select});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      started_q <= 1'b0;
      bw_eff_q <= '0;
      wr8_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
      bw_eff_q <= {filter_widest_force, filter_bandwidth_select};
      // write strobe delayed so the forced policy acts once the new code is in
      wr8_q <= wr8;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_cal_pulse <= 1'b0;
    end else if (filter_widest_force) begin
      filter_cal_pulse <= 1'b0;
    end else begin
      unique case (cal_pol)
        rxcfg_pkg::POL_STARTUP: filter_cal_pulse <= !started_q;
        rxcfg_pkg::POL_OFF: filter_cal_pulse <= 1'b0;
        rxcfg_pkg::POL_ON_CHANGE: filter_cal_pulse <= bw_changed;
        rxcfg_pkg::POL_FORCE: filter_cal_pulse <= wr8_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_init_pulse <= 1'b0;
    end else begin
      unique case (init_pol)
        rxcfg_pkg::POL_STARTUP: filter_init_pulse <= !started_q;
        rxcfg_pkg::POL_OFF: filter_init_pulse <= 1'b0;
        rxcfg_pkg::POL_ON_CHANGE: filter_init_pulse <= bw_changed;
        rxcfg_pkg::POL_FORCE: filter_init_pulse <= wr8_q;
      endcase
    end
  end

  // level meter reading from the analog side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_meta_q <= '0;
      level_sync_q <= '0;
    end else begin
      level_meta_q <= level_meter_reading;
      level_sync_q <= level_meta_q;
    end
  end

  // frequency correction run: start on a zero write, clear on done
  assign afc_go = wr9 && !pwdata[rxcfg_pkg::L_AFC_RUN] && !afc_busy_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      afc_busy_q <= 1'b0;
      afc_result_q <= 1'b0;
      freq_correction_start <= 1'b0;
    end else begin
      freq_correction_start <= afc_go;
      if (afc_go) begin
        afc_busy_q <= 1'b1;
      end else if (freq_correction_done) begin
        afc_busy_q <= 1'b0;
      end
      if (afc_busy_q && freq_correction_done && !afc_go) begin
        afc_result_q <= freq_correction_fail;
      end
    end
  end

  // integrator overflow: sticky, set wins over a clear in the same cycle
  assign ovf_clr = wr10 && pwdata[rxcfg_pkg::M_OVERFLOW];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_q <= 1'b0;
      freq_correction_integrator_reset <= 1'b0;
    end else begin
      freq_correction_integrator_reset <= ovf_clr;
      if (freq_correction_integrator_overflow) begin
        overflow_q <= 1'b1;
      end else if (ovf_clr) begin
        overflow_q <= 1'b0;
      end
    end
  end

  rxcfg_pattern_match #(
    .WIDTH(32)
  ) u_match (
    .pclk(pclk),
    .presetn(presetn),
    .enable(pattern_enable),
    .len_code(pattern_size),
    .tol_code(pattern_tolerance),
    .ref_pattern(pattern_q),
    .bit_in(demod_bit),
    .bit_valid(demod_bit_valid),
    .match(pattern_match)
  );

  AST_BW_FIELD: assert property (@(posedge pclk) disable iff (!presetn)
    wr8 |=> filter_bandwidth_select == $past(pwdata[6:5]))
    else $error("bandwidth select not taken from the write");
  AST_WIDEST_NO_CAL: assert property (@(posedge pclk) disable iff (!presetn)
    $past(filter_widest_force) && filter_widest_force |-> !filter_cal_pulse)
    else $error("calibration while widest bandwidth forced");
  AST_CAL_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
    wr8 && pwdata[3:2] == 2'b11 && !pwdata[4] |=> ##1 filter_cal_pulse)
    else $error("forced calibration write gave no pulse");
  AST_CAL_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    wr8 && pwdata[3:2] == 2'b01 |=> ##1 !filter_cal_pulse)
    else $error("calibration pulse with calibration off");
  AST_INIT_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
    wr8 && pwdata[1:0] == 2'b11 |=> ##1 filter_init_pulse)
    else $error("forced initialisation write gave no pulse");
  AST_LEVEL_READ: assert property (@(posedge pclk) disable iff (!presetn)
    ready_q && hit9 && !pwrite |-> prdata[5:4] == $past(level_sync_q))
    else $error("level reading not returned");
  AST_FREQ_ERR_EN: assert property (@(posedge pclk) disable iff (!presetn)
    wr9 |=> freq_error_meter_enable == $past(pwdata[3]))
    else $error("error meter enable not taken from the write");
  AST_FREQ_CORRECTION_TRIGGER: assert property (@(posedge pclk) disable iff (!presetn)
    wr9 && !pwdata[2] && !afc_busy_q |=> afc_busy_q && freq_correction_start)
    else $error("correction run not started by a zero write");
  AST_AFC_END: assert property (@(posedge pclk) disable iff (!presetn)
    afc_busy_q && freq_correction_done && !afc_go
    |=> !afc_busy_q && afc_result_q == $past(freq_correction_fail))
    else $error("correction run end or result wrong");
  AST_APPLY_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    wr9 |=> freq_correction_apply_off == $past(pwdata[0]))
    else $error("apply-off bit not taken from the write");
  AST_OVF_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    freq_correction_integrator_overflow |=> overflow_q)
    else $error("overflow flag lost");
  AST_OVF_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    ovf_clr |=> freq_correction_integrator_reset)
    else $error("integrator reset pulse missing");
  AST_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    wr10 |=> rx_mode_linear == $past(pwdata[5]))
    else $error("mode bit not taken from the write");
  AST_PSIZE: assert property (@(posedge pclk) disable iff (!presetn)
    wr10 |=> pattern_size == $past(pwdata[3:2]))
    else $error("pattern size not taken from the write");
  AST_READBACK: assert property (@(posedge pclk) disable iff (!presetn)
    ready_q && hit8 && !pwrite |-> prdata[7:0] == filter_q)
    else $error("filter register read back wrong");

  COV_AFC_RUN: cover property (@(posedge pclk) disable iff (!presetn)
    freq_correction_start ##[1:50] (afc_busy_q && freq_correction_done));
  COV_CAL_FORCE: cover property (@(posedge pclk) disable iff (!presetn)
    filter_cal_pulse && cal_pol == rxcfg_pkg::POL_FORCE);
  COV_OVF_CLEAR: cover property (@(posedge pclk) disable iff (!presetn)
    overflow_q ##1 freq_correction_integrator_reset);
  COV_MATCH: cover property (@(posedge pclk) disable iff (!presetn) pattern_match);

endmodule // rxcfg_regs

// File: rxcfg_pkg.sv
/*
 * Constants for the receiver configuration register bank: register indices,
 * byte addresses, field positions, reset values and the filter policy codes.
 * Assumes a 32-bit APB bus with one aligned word per register.
 */
//
// Overview of operation
// - Bits 6-5 of register 8 pick filter bandwidth 10, 20, 40, 200 kHz.
// - Bit 4 of register 8 forces widest filter and suppresses calibration.
// - Bits 3-2: calibrate at start-up, never, on bandwidth change, or per write.
// - Bits 1-0: initialise at start-up, reserved, on change, or forced.
// - Bits 5-4 of register 9 read back the signal level band.
// - Bit 3 of register 9 switches the frequency error meter on.
// - Writing zero to bit 2 starts correction; bit reads one until done.
// - Bit 1 of register 9 holds the correction result, one meaning failure.
// - Bit 0 of register 9 at one stops applying the correction.
// - Bit 7 of register 10 flags integrator overflow; writing one resets it.
// - Bit 5 of register 10 selects sensitivity mode A or linearity mode B.
// - Bits 3-2 of register 10 set pattern length 8, 16, 24, 32 bits.
// - Bits 1-0 of register 10 set zero to three tolerated mismatched bits.
// - Earliest received bit meets pattern MSB, last received meets used LSB.
package rxcfg_pkg;

  // register indices and their byte addresses (index times four)
  localparam logic [7:0] IDX_FILTER = 8'h08;
  localparam logic [7:0] IDX_LEVEL_AFC = 8'h09;
  localparam logic [7:0] IDX_MODE_PAT = 8'h0A;
  localparam logic [7:0] IDX_PATTERN = 8'h0D;
  localparam logic [7:0] ADDR_FILTER = 8'h20;
  localparam logic [7:0] ADDR_LEVEL_AFC = 8'h24;
  localparam logic [7:0] ADDR_MODE_PAT = 8'h28;
  localparam logic [7:0] ADDR_PATTERN = 8'h34;

  // filter setup fields
  localparam int F_BITSYNC_OFF = 7;
  localparam int F_BW_LSB = 5;
  localparam int F_WIDEST = 4;
  localparam int F_CAL_LSB = 2;
  localparam int F_INIT_LSB = 0;

  // level and frequency correction fields
  localparam int L_ENABLE = 7;
  localparam int L_RANGE = 6;
  localparam int L_READING_LSB = 4;
  localparam int L_FREQ_ERR = 3;
  localparam int L_AFC_RUN = 2;
  localparam int L_AFC_RESULT = 1;
  localparam int L_AFC_APPLY_OFF = 0;

  // mode and pattern fields
  localparam int M_OVERFLOW = 7;
  localparam int M_QUAD_AMP = 6;
  localparam int M_LINEAR = 5;
  localparam int M_PATTERN_ON = 4;
  localparam int M_PLEN_LSB = 2;
  localparam int M_TOL_LSB = 0;

  // reset values
  localparam logic [7:0] FILTER_RST = 8'h00;
  localparam logic [7:0] LEVEL_AFC_RST = 8'h00;
  localparam logic [7:0] MODE_PAT_RST = 8'h00;
  localparam logic [31:0] PATTERN_RST = 32'h00000000;

  // bits software writes and reads back in the level-and-correction and mode-and-pattern registers
  localparam logic [7:0] LEVEL_AFC_RW_MASK = 8'hC9;
  localparam logic [7:0] MODE_PAT_RW_MASK = 8'h7F;

  // calibration and initialisation policy codes, in field order
  typedef enum logic [1:0] {
    POL_STARTUP,
    POL_OFF,
    POL_ON_CHANGE,
    POL_FORCE
  } rxcfg_policy_t;

endpackage

// File: rxcfg_pattern_match.sv
/*
 * Pattern matcher: compares the newest received bits with the top of the
 * reference pattern, allowing a programmed number of mismatches.
 * Assumes demodulated bits arrive on pclk with a one-cycle valid strobe.
 */
`timescale 1ns/10ps
module rxcfg_pattern_match #(
  parameter int WIDTH = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [1:0] len_code,
  input wire logic [1:0] tol_code,
  input wire logic [WIDTH-1:0] ref_pattern,
  input wire logic bit_in,
  input wire logic bit_valid,
  output logic match
);
  logic [WIDTH-1:0] shift_q, shift_d, aligned, mask, diff;
  logic [6:0] seen_q, nbits;
  logic [6:0] errs;
  logic hit;

  // newest bit enters the lsb, so the earliest sits at the window top
  assign shift_d = {shift_q[WIDTH-2:0], bit_in};
  // three-bit sum so that code 11 gives 32 and does not wrap to 0
  assign nbits = {1'b0, 3'({1'b0, len_code}) + 3'd1, 3'b000};
  assign aligned = ref_pattern >> (7'(WIDTH) - nbits);
  assign mask = (nbits >= 7'(WIDTH)) ? '1 : ((WIDTH'(1) << nbits) - WIDTH'(1));

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_diff
      assign diff[i] = (shift_d[i] ^ aligned[i]) & mask[i];
    end
  endgenerate

  always_comb begin
    errs = '0;
    for (int k = 0; k < WIDTH; k++) begin
      errs = errs + 7'(diff[k]);
    end
  end

  assign hit = enable && bit_valid && (seen_q + 7'd1 >= nbits)
               && (errs <= {5'b00000, tol_code});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= '0;
      seen_q <= '0;
    end else if (!enable) begin
      seen_q <= '0;
    end else if (bit_valid) begin
      shift_q <= shift_d;
      if (seen_q < 7'(WIDTH)) begin
        seen_q <= seen_q + 7'd1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match <= 1'b0;
    end else begin
      match <= hit;
    end
  end

  AST_MATCH_TOL: assert property (@(posedge pclk) disable iff (!presetn)
    match |-> $past(errs) <= {5'b00000, $past(tol_code)})
    else $error("pattern match reported with too many mismatches");
  AST_MATCH_ONLY_ON_BIT: assert property (@(posedge pclk) disable iff (!presetn)
    match |-> $past(bit_valid) && $past(enable))
    else $error("pattern match without a received bit");

endmodule // rxcfg_pattern_match

// File: rxcfg_regs_tb.sv
/*
 * Self-checking testbench for the receiver configuration register bank.
 * Assumes the rxcfg_regs top as declared, with pready one access cycle late.
 */
`timescale 1ns/10ps
module rxcfg_regs_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, bit_sync_disable, filter_widest_force, filter_cal_pulse;
  logic [1:0] filter_bandwidth_select, pattern_size, pattern_tolerance;
  logic filter_init_pulse, level_meter_enable, level_meter_range, freq_error_meter_enable;
  logic freq_correction_start, freq_correction_apply_off, freq_correction_integrator_reset;
  logic quadrature_amp_enable, rx_mode_linear, pattern_enable, pattern_match;
  logic [1:0] level_meter_reading = 2'h0;
  logic freq_correction_done = 1'b0;
  logic freq_correction_fail = 1'b0;
  logic freq_correction_integrator_overflow = 1'b0;
  logic demod_bit = 1'b0;
  logic demod_bit_valid = 1'b0;
  int n_mismatch = 0;
  int comparisons = 0;
  int n_cal = 0;
  int n_init = 0;
  int n_start = 0;
  int n_irst = 0;
  int n_match = 0;

  rxcfg_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bit_sync_disable(bit_sync_disable),
    .filter_bandwidth_select(filter_bandwidth_select),
    .filter_widest_force(filter_widest_force), .filter_cal_pulse(filter_cal_pulse),
    .filter_init_pulse(filter_init_pulse), .level_meter_enable(level_meter_enable),
    .level_meter_range(level_meter_range), .level_meter_reading(level_meter_reading),
    .freq_error_meter_enable(freq_error_meter_enable),
    .freq_correction_start(freq_correction_start),
    .freq_correction_done(freq_correction_done),
    .freq_correction_fail(freq_correction_fail),
    .freq_correction_apply_off(freq_correction_apply_off),
    .freq_correction_integrator_overflow(freq_correction_integrator_overflow),
    .freq_correction_integrator_reset(freq_correction_integrator_reset),
    .quadrature_amp_enable(quadrature_amp_enable), .rx_mode_linear(rx_mode_linear),
    .pattern_enable(pattern_enable), .pattern_size(pattern_size),
    .pattern_tolerance(pattern_tolerance), .demod_bit(demod_bit),
    .demod_bit_valid(demod_bit_valid), .pattern_match(pattern_match));

  always #20 pclk = ~pclk;

  // pulse counters, sampled before the edge's own updates land
  always @(posedge pclk) begin
    if (filter_cal_pulse === 1'b1) n_cal++;
    if (filter_init_pulse === 1'b1) n_init++;
    if (freq_correction_start === 1'b1) n_start++;
    if (freq_correction_integrator_reset === 1'b1) n_irst++;
    if (pattern_match === 1'b1) n_match++;
  end

  task automatic finish_test;
    $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  // one apb transfer; entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) chk(32'h0, 32'h1, "pready never came");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0, "write error");
  endtask

  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk({31'h0, e}, 32'h0, "read error");
    chk(r & m, exp, "read data");
  endtask

  task automatic filt(input logic [7:0] v, input int dc, input int di);
    int c0, i0;
    c0 = n_cal;
    i0 = n_init;
    wr(rxcfg_pkg::ADDR_FILTER, {24'h0, v});
    chk({30'h0, filter_bandwidth_select}, {30'h0, v[6:5]}, "bandwidth");
    chk({31'h0, filter_widest_force}, {31'h0, v[4]}, "widest");
    repeat (4) @(posedge pclk);
    chk(n_cal - c0, dc, "cal pulses");
    chk(n_init - i0, di, "init pulses");
    rdm(rxcfg_pkg::ADDR_FILTER, 32'hFFFFFFFF, {24'h0, v});
  endtask

  task automatic t_reset_values;
    chk(n_cal, 1, "startup cal");
    chk(n_init, 1, "startup init");
    rdm(rxcfg_pkg::ADDR_FILTER, 32'hFFFFFFFF, 32'h0);
    rdm(rxcfg_pkg::ADDR_LEVEL_AFC, 32'hFFFFFFFF, 32'h0);
    rdm(rxcfg_pkg::ADDR_MODE_PAT, 32'hFFFFFFFF, 32'h0);
  endtask

  task automatic t_filter;
    filt(8'hF5, 0, 0);
    chk({31'h0, bit_sync_disable}, 32'h1, "bit sync off");
    for (int b = 0; b < 4; b++) filt(8'h05 | 8'(b << 5), 0, 0);
    filt(8'h0F, 1, 1);
    filt(8'h1C, 0, 0);
    filt(8'h0A, 1, 1);
    // 40 kHz left as the working bandwidth, wide enough for the test signal
    filt(8'h4A, 1, 1);
    filt(8'h4A, 0, 0);
  endtask

  task automatic done(input logic f);
    freq_correction_fail <= f;
    freq_correction_done <= 1'b1;
    @(posedge pclk);
    freq_correction_done <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic t_afc;
    int s0;
    s0 = n_start;
    wr(rxcfg_pkg::ADDR_LEVEL_AFC, 32'h08);
    chk({31'h0, freq_error_meter_enable}, 32'h1, "error meter on");
    rdm(rxcfg_pkg::ADDR_LEVEL_AFC, 32'h0F, 32'h0C);
    wr(rxcfg_pkg::ADDR_LEVEL_AFC, 32'h08);
    chk(n_start - s0, 1, "one start while busy");
    done(1'b1);
    rdm(rxcfg_pkg::ADDR_LEVEL_AFC, 32'h0F, 32'h0A);
    wr(rxcfg_pkg::ADDR_LEVEL_AFC, 32'h01);
    chk({31'h0, freq_correction_apply_off}, 32'h1, "apply off");
    chk({31'h0, freq_error_meter_enable}, 32'h0, "error meter off");
    done(1'b0);
    chk(n_start - s0, 2, "second start");
    rdm(rxcfg_pkg::ADDR_LEVEL_AFC, 32'h0F, 32'h01);
  endtask

  task automatic t_level;
    // bit 2 written as one so no correction run starts
    wr(rxcfg_pkg::ADDR_LEVEL_AFC, 32'hC4);
    chk({30'h0, level_meter_enable, level_meter_range}, 32'h3, "meter controls");
    for (int i = 0; i < 4; i++) begin
      level_meter_reading <= 2'(i);
      repeat (4) @(posedge pclk);
      rdm(rxcfg_pkg::ADDR_LEVEL_AFC, 32'hF4, 32'hC0 | 32'(i << 4));
    end
  endtask

  task automatic t_overflow_mode;
    int r0;
    r0 = n_irst;
    freq_correction_integrator_overflow <= 1'b1;
    @(posedge pclk);
    freq_correction_integrator_overflow <= 1'b0;
    rdm(rxcfg_pkg::ADDR_MODE_PAT, 32'hFF, 32'h80);
    wr(rxcfg_pkg::ADDR_MODE_PAT, 32'h80);
    repeat (2) @(posedge pclk);
    chk(n_irst - r0, 1, "integrator reset");
    rdm(rxcfg_pkg::ADDR_MODE_PAT, 32'hFF, 32'h00);
    wr(rxcfg_pkg::ADDR_MODE_PAT, 32'h6F);
    chk({31'h0, rx_mode_linear}, 32'h1, "mode b");
    chk({30'h0, pattern_size}, 32'h3, "size");
    chk({30'h0, pattern_tolerance}, 32'h3, "tolerance");
    chk({31'h0, quadrature_amp_enable}, 32'h1, "quad amp");
    rdm(rxcfg_pkg::ADDR_MODE_PAT, 32'hFF, 32'h6F);
  endtask

  task automatic bits(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      demod_bit <= b[i];
      demod_bit_valid <= 1'b1;
      @(posedge pclk);
    end
    demod_bit_valid <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic t_pattern;
    int m0;
    wr(rxcfg_pkg::ADDR_PATTERN, 32'h93000000);
    rdm(rxcfg_pkg::ADDR_PATTERN, 32'hFFFFFFFF, 32'h93000000);
    wr(rxcfg_pkg::ADDR_MODE_PAT, 32'h10);
    chk({31'h0, pattern_enable}, 32'h1, "pattern on");
    m0 = n_match;
    bits(8'h93);
    chk(n_match - m0, 1, "exact match");
    bits(8'h92);
    chk(n_match - m0, 1, "one error no tolerance");
    wr(rxcfg_pkg::ADDR_MODE_PAT, 32'h11);
    bits(8'h92);
    chk(n_match - m0, 2, "one error tolerated");
    // full 32-bit reference, no tolerance: only the last window matches
    wr(rxcfg_pkg::ADDR_MODE_PAT, 32'h1C);
    bits(8'h93);
    bits(8'h00);
    bits(8'h00);
    bits(8'h00);
    chk(n_match - m0, 3, "full length match");
  endtask

  task automatic t_unmapped;
    logic [31:0] r;
    logic e;
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "unmapped read error");
    chk(r, 32'h0, "unmapped read data");
    apb(1'b1, 8'h40, 32'hFF, r, e);
    chk({31'h0, e}, 32'h1, "unmapped write error");
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_reset_values;
    t_filter;
    t_afc;
    t_level;
    t_overflow_mode;
    t_pattern;
    t_unmapped;
    finish_test;
  end

  initial begin
    repeat (6000) @(posedge pclk);
    n_mismatch++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test;
  end
endmodule // rxcfg_regs_tb
